// ==== include/iso_irq_pkg.sv ====
// Package for the isochronous context interrupt registers
package iso_irq_pkg;
    localparam int TX_CTX = 8;
    localparam int RX_CTX = 4;
    localparam int BW_W   = 13;
    localparam int ADDR_W = 8;

    localparam logic [7:0] ADDR_TX_EVENT_SET   = 8'h90;
    localparam logic [7:0] ADDR_TX_EVENT_CLEAR = 8'h94;
    localparam logic [7:0] ADDR_TX_MASK_SET    = 8'h98;
    localparam logic [7:0] ADDR_TX_MASK_CLEAR  = 8'h9c;
    localparam logic [7:0] ADDR_RX_EVENT_SET   = 8'ha0;
    localparam logic [7:0] ADDR_RX_EVENT_CLEAR = 8'ha4;
    localparam logic [7:0] ADDR_RX_MASK_SET    = 8'ha8;
    localparam logic [7:0] ADDR_RX_MASK_CLEAR  = 8'hac;
    localparam logic [7:0] ADDR_INIT_BW        = 8'hb0;
    localparam logic [7:0] ADDR_MAIN_MASK      = 8'hb8;

    localparam logic [12:0] INIT_BW_RESET = 13'h1333;
    localparam logic [7:0]  TX_ZERO       = 8'h00;
    localparam logic [3:0]  RX_ZERO       = 4'h0;
    localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;

    // Summary positions in the main mask word
    localparam int TX_SUMMARY_BIT = 6;
    localparam int RX_SUMMARY_BIT = 7;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic [7:0]  tx_event;
        logic [7:0]  tx_mask;
        logic [3:0]  rx_event;
        logic [3:0]  rx_mask;
        logic [7:0]  tx_irq_prev;
        logic [3:0]  rx_irq_prev;
        logic [12:0] init_bw;
        logic [12:0] bw_avail;
        logic        bw_load;
        logic        main_tx_mask;
        logic        main_rx_mask;
        logic        tx_summary;
        logic        rx_summary;
        logic        irq;
        logic [31:0] rdata;
    } state_t;
endpackage

// ==== rtl/iso_context_irq_regs.sv ====
// Per-context isochronous interrupt latches and initial bandwidth register
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
module iso_context_irq_regs
(
    input  wire logic        i_mclk,
    input  wire logic        i_nrst,
    input  wire logic        i_soft_rst,
    input  wire logic        i_global_reset_pin,
    input  wire logic        i_perst,
    input  wire logic        i_pci_bus_reset_pin,
    input  wire logic        i_serial_bus_reset,
    input  wire logic [7:0]  i_tx_ctx_irq,
    input  wire logic [3:0]  i_rx_ctx_irq,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    output logic             o_tx_summary_event,
    output logic             o_rx_summary_event,
    output logic             o_irq,
    output logic      [12:0] o_bw_avail,
    output logic             o_bw_load
);
    iso_irq_pkg::state_t   s_q;
    iso_irq_pkg::state_t   s_d;
    iso_irq_pkg::reg_req_t req;
    logic                  load_evt;
    logic [7:0]            tx_rise;
    logic [3:0]            rx_rise;
    logic [7:0]            tx_masked;
    logic [3:0]            rx_masked;

    assign req.addr  = i_addr;
    assign req.wdata = i_wdata;
    assign req.wr    = i_wr;
    assign req.rd    = i_rd;

    // Context logic pulses its line on a flagged descriptor completion
    assign tx_rise   = i_tx_ctx_irq & ~s_q.tx_irq_prev;
    assign rx_rise   = i_rx_ctx_irq & ~s_q.rx_irq_prev;
    assign tx_masked = s_q.tx_event & s_q.tx_mask;
    assign rx_masked = s_q.rx_event & s_q.rx_mask;
    assign load_evt  = i_global_reset_pin | i_perst | i_pci_bus_reset_pin | i_serial_bus_reset;

    always_comb
    begin
        s_d             = s_q;
        s_d.tx_irq_prev = i_tx_ctx_irq;
        s_d.rx_irq_prev = i_rx_ctx_irq;
        s_d.rdata       = iso_irq_pkg::WORD_ZERO;
        s_d.bw_load     = 1'b0;
        if (req.wr)
        begin
            case (req.addr)
                iso_irq_pkg::ADDR_TX_EVENT_SET:
                    s_d.tx_event = s_q.tx_event | req.wdata[7:0];
                iso_irq_pkg::ADDR_TX_EVENT_CLEAR:
                    s_d.tx_event = s_q.tx_event & ~req.wdata[7:0];
                iso_irq_pkg::ADDR_TX_MASK_SET:
                    s_d.tx_mask = s_q.tx_mask | req.wdata[7:0];
                iso_irq_pkg::ADDR_TX_MASK_CLEAR:
                    s_d.tx_mask = s_q.tx_mask & ~req.wdata[7:0];
                iso_irq_pkg::ADDR_RX_EVENT_SET:
                    s_d.rx_event = s_q.rx_event | req.wdata[3:0];
                iso_irq_pkg::ADDR_RX_EVENT_CLEAR:
                    s_d.rx_event = s_q.rx_event & ~req.wdata[3:0];
                iso_irq_pkg::ADDR_RX_MASK_SET:
                    s_d.rx_mask = s_q.rx_mask | req.wdata[3:0];
                iso_irq_pkg::ADDR_RX_MASK_CLEAR:
                    s_d.rx_mask = s_q.rx_mask & ~req.wdata[3:0];
                iso_irq_pkg::ADDR_INIT_BW:
                    s_d.init_bw = req.wdata[12:0];
                iso_irq_pkg::ADDR_MAIN_MASK:
                begin
                    s_d.main_tx_mask = req.wdata[iso_irq_pkg::TX_SUMMARY_BIT];
                    s_d.main_rx_mask = req.wdata[iso_irq_pkg::RX_SUMMARY_BIT];
                end
                default:
                    s_d.rdata = iso_irq_pkg::WORD_ZERO;
            endcase
        end
        // Hardware edges are ORed in after the write decode so a same-cycle clear write cannot lose them; a soft reset still clears them
        s_d.tx_event = s_d.tx_event | tx_rise;
        s_d.rx_event = s_d.rx_event | rx_rise;
        if (req.rd)
        begin
            case (req.addr)
                iso_irq_pkg::ADDR_TX_EVENT_SET:
                    s_d.rdata = {24'h000000, s_q.tx_event};
                iso_irq_pkg::ADDR_TX_EVENT_CLEAR:
                    s_d.rdata = {24'h000000, tx_masked};
                iso_irq_pkg::ADDR_TX_MASK_SET,
                iso_irq_pkg::ADDR_TX_MASK_CLEAR:
                    s_d.rdata = {24'h000000, s_q.tx_mask};
                iso_irq_pkg::ADDR_RX_EVENT_SET:
                    s_d.rdata = {28'h0000000, s_q.rx_event};
                iso_irq_pkg::ADDR_RX_EVENT_CLEAR:
                    s_d.rdata = {28'h0000000, rx_masked};
                iso_irq_pkg::ADDR_RX_MASK_SET,
                iso_irq_pkg::ADDR_RX_MASK_CLEAR:
                    s_d.rdata = {28'h0000000, s_q.rx_mask};
                iso_irq_pkg::ADDR_INIT_BW:
                    s_d.rdata = {19'h00000, s_q.init_bw};
                iso_irq_pkg::ADDR_MAIN_MASK:
                    s_d.rdata = {24'h000000, s_q.main_rx_mask, s_q.main_tx_mask, 6'h00};
                default:
                    s_d.rdata = iso_irq_pkg::WORD_ZERO;
            endcase
        end
        // Summaries lag the event latches by one cycle; kept registered for clean outputs
        s_d.tx_summary = |tx_masked;
        s_d.rx_summary = |rx_masked;
        s_d.irq = (s_q.tx_summary & s_q.main_tx_mask) | (s_q.rx_summary & s_q.main_rx_mask);
        if (load_evt)
        begin
            s_d.bw_avail = s_q.init_bw;
            s_d.bw_load  = 1'b1;
        end
        if (i_soft_rst)
        begin
            s_d.tx_event     = iso_irq_pkg::TX_ZERO;
            s_d.tx_mask      = iso_irq_pkg::TX_ZERO;
            s_d.rx_event     = iso_irq_pkg::RX_ZERO;
            s_d.rx_mask      = iso_irq_pkg::RX_ZERO;
            s_d.init_bw      = iso_irq_pkg::INIT_BW_RESET;
            s_d.bw_avail     = iso_irq_pkg::INIT_BW_RESET;
            s_d.bw_load      = 1'b1;
            s_d.main_tx_mask = 1'b0;
            s_d.main_rx_mask = 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            s_q          <= '0;
            s_q.init_bw  <= iso_irq_pkg::INIT_BW_RESET;
            s_q.bw_avail <= iso_irq_pkg::INIT_BW_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_rdata            = s_q.rdata;
    assign o_tx_summary_event = s_q.tx_summary;
    assign o_rx_summary_event = s_q.rx_summary;
    assign o_irq              = s_q.irq;
    assign o_bw_avail         = s_q.bw_avail;
    assign o_bw_load          = s_q.bw_load;

    // Event latches: hardware edges and software writes
    a_tx_edge_sets: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (tx_rise[0] && !i_soft_rst) |=> s_q.tx_event[0])
        else $error("tx edge did not set event");

    a_rx_edge_sets: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (rx_rise[3] && !i_soft_rst) |=> s_q.rx_event[3])
        else $error("rx edge did not set event");

    a_tx_set_write: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_wr && i_addr == iso_irq_pkg::ADDR_TX_EVENT_SET && !i_soft_rst)
        |=> (s_q.tx_event & $past(i_wdata[7:0])) == $past(i_wdata[7:0]))
        else $error("tx set write did not set event");

    a_rx_set_write: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_wr && i_addr == iso_irq_pkg::ADDR_RX_EVENT_SET && !i_soft_rst)
        |=> (s_q.rx_event & $past(i_wdata[3:0])) == $past(i_wdata[3:0]))
        else $error("rx set write did not set event");

    a_event_hold: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (s_q.tx_event[2] && !i_soft_rst
         && !(i_wr && i_addr == iso_irq_pkg::ADDR_TX_EVENT_CLEAR && i_wdata[2]))
        |=> s_q.tx_event[2])
        else $error("tx event cleared without clear write");

    a_rx_event_hold: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (s_q.rx_event[1] && !i_soft_rst
         && !(i_wr && i_addr == iso_irq_pkg::ADDR_RX_EVENT_CLEAR && i_wdata[1]))
        |=> s_q.rx_event[1])
        else $error("rx event cleared without clear write");

    a_tx_clr_write: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_wr && i_addr == iso_irq_pkg::ADDR_TX_EVENT_CLEAR && !i_soft_rst)
        |=> (s_q.tx_event & $past(i_wdata[7:0])) == ($past(tx_rise) & $past(i_wdata[7:0])))
        else $error("tx clear write did not clear event");

    a_rx_clr_write: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_wr && i_addr == iso_irq_pkg::ADDR_RX_EVENT_CLEAR && !i_soft_rst)
        |=> (s_q.rx_event & $past(i_wdata[3:0])) == ($past(rx_rise) & $past(i_wdata[3:0])))
        else $error("rx clear write did not clear event");

    // Every context line is checked, not only the two sampled above
    for (genvar c = 0; c < iso_irq_pkg::TX_CTX; c++)
    begin : g_tx_edge
        a_tx_ctx_edge: assert property (@(posedge i_mclk) disable iff (!i_nrst)
            (tx_rise[c] && !i_soft_rst) |=> s_q.tx_event[c])
            else $error("tx context edge did not set event");
    end

    for (genvar c = 0; c < iso_irq_pkg::RX_CTX; c++)
    begin : g_rx_edge
        a_rx_ctx_edge: assert property (@(posedge i_mclk) disable iff (!i_nrst)
            (rx_rise[c] && !i_soft_rst) |=> s_q.rx_event[c])
            else $error("rx context edge did not set event");
    end

    // Mask writes and read-back paths: masked views, mask set/clear, mask mirrors, reserved bits and bandwidth
    a_tx_clr_read: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_rd && i_addr == iso_irq_pkg::ADDR_TX_EVENT_CLEAR)
        |=> o_rdata == {24'h000000, $past(s_q.tx_event) & $past(s_q.tx_mask)})
        else $error("tx clear read not masked");

    a_rx_clr_read: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_rd && i_addr == iso_irq_pkg::ADDR_RX_EVENT_CLEAR)
        |=> o_rdata == {28'h0000000, $past(s_q.rx_event) & $past(s_q.rx_mask)})
        else $error("rx clear read not masked");

    a_tx_mask_set: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_wr && i_addr == iso_irq_pkg::ADDR_TX_MASK_SET && !i_soft_rst)
        |=> (s_q.tx_mask & $past(i_wdata[7:0])) == $past(i_wdata[7:0]))
        else $error("tx mask set failed");

    a_tx_mask_clr: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_wr && i_addr == iso_irq_pkg::ADDR_TX_MASK_CLEAR)
        |=> (s_q.tx_mask & $past(i_wdata[7:0])) == 8'h00)
        else $error("tx mask clear failed");

    a_rx_mask_set: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_wr && i_addr == iso_irq_pkg::ADDR_RX_MASK_SET && !i_soft_rst)
        |=> (s_q.rx_mask & $past(i_wdata[3:0])) == $past(i_wdata[3:0]))
        else $error("rx mask set failed");

    a_rx_mask_clr: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_wr && i_addr == iso_irq_pkg::ADDR_RX_MASK_CLEAR)
        |=> (s_q.rx_mask & $past(i_wdata[3:0])) == 4'h0)
        else $error("rx mask clear failed");

    a_mask_read: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_rd && (i_addr == iso_irq_pkg::ADDR_TX_MASK_SET
                  || i_addr == iso_irq_pkg::ADDR_TX_MASK_CLEAR))
        |=> o_rdata == {24'h000000, $past(s_q.tx_mask)})
        else $error("tx mask read wrong");

    a_rx_mask_read: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_rd && (i_addr == iso_irq_pkg::ADDR_RX_MASK_SET
                  || i_addr == iso_irq_pkg::ADDR_RX_MASK_CLEAR))
        |=> o_rdata == {28'h0000000, $past(s_q.rx_mask)})
        else $error("rx mask read wrong");

    a_tx_upper_zero: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_rd && (i_addr == iso_irq_pkg::ADDR_TX_EVENT_SET
                  || i_addr == iso_irq_pkg::ADDR_TX_EVENT_CLEAR))
        |=> o_rdata[31:8] == 24'h000000)
        else $error("tx reserved bits not zero");

    a_rx_upper_zero: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        ##1 $past(i_rd && i_addr == iso_irq_pkg::ADDR_RX_EVENT_SET)
        |-> o_rdata[31:4] == 28'h0000000)
        else $error("rx reserved bits not zero");

    a_bw_read: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_rd && i_addr == iso_irq_pkg::ADDR_INIT_BW)
        |=> o_rdata == {19'h00000, $past(s_q.init_bw)})
        else $error("bandwidth read wrong");

    // Summary and main request; each stage adds one cycle of lag
    a_tx_summary: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        1'b1 |=> o_tx_summary_event == $past(|(s_q.tx_event & s_q.tx_mask)))
        else $error("tx summary does not follow masked events");

    a_rx_summary: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        1'b1 |=> o_rx_summary_event == $past(|(s_q.rx_event & s_q.rx_mask)))
        else $error("rx summary does not follow masked events");

    a_summary_irq: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (|tx_masked && s_q.main_tx_mask) |-> ##2 (o_irq || !$past(s_q.main_tx_mask)))
        else $error("tx summary did not interrupt");

    a_rx_summary_irq: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (|rx_masked && s_q.main_rx_mask) |-> ##2 (o_irq || !$past(s_q.main_rx_mask)))
        else $error("rx summary did not interrupt");

    a_tx_irq_gate: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (!s_q.main_tx_mask && !(s_q.rx_summary && s_q.main_rx_mask)) |=> !o_irq)
        else $error("interrupt without enabled summary");

    a_rx_irq_gate: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (!s_q.main_rx_mask && !(s_q.tx_summary && s_q.main_tx_mask)) |=> !o_irq)
        else $error("interrupt without enabled summary");

    // Resets and the bandwidth copy
    a_soft_clear: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_soft_rst
        |=> (s_q.tx_event == iso_irq_pkg::TX_ZERO && s_q.tx_mask == iso_irq_pkg::TX_ZERO
             && s_q.rx_event == iso_irq_pkg::RX_ZERO && s_q.rx_mask == iso_irq_pkg::RX_ZERO))
        else $error("soft reset left event or mask bits");

    a_soft_bw: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_soft_rst |=> (s_q.init_bw == iso_irq_pkg::INIT_BW_RESET
                        && o_bw_avail == iso_irq_pkg::INIT_BW_RESET && o_bw_load))
        else $error("soft reset did not restore bandwidth");

    a_bw_copy: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_serial_bus_reset && !i_soft_rst) |=> o_bw_load && o_bw_avail == $past(s_q.init_bw))
        else $error("bandwidth not copied");

    a_bw_any_load: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (load_evt && !i_soft_rst) |=> o_bw_load && o_bw_avail == $past(s_q.init_bw))
        else $error("bandwidth not copied on reset input");

    a_bw_load_pulse: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (!load_evt && !i_soft_rst) |=> !o_bw_load)
        else $error("bandwidth load without reset input");

    a_bw_avail_hold: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (!load_evt && !i_soft_rst) |=> $stable(o_bw_avail))
        else $error("bandwidth resource changed without load");

    a_bw_keep: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (i_serial_bus_reset && !i_soft_rst && !i_wr) |=> $stable(s_q.init_bw))
        else $error("bus reset changed bandwidth field");
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the isochronous context interrupt registers
`timescale 1ns/10ps
module testbench;
    logic        i_mclk;
    logic        i_nrst;
    logic        i_soft_rst;
    logic [3:0]  bw_src;
    logic [7:0]  i_tx_ctx_irq;
    logic [3:0]  i_rx_ctx_irq;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [31:0] o_rdata;
    logic        o_tx_summary_event;
    logic        o_rx_summary_event;
    logic        o_irq;
    logic [12:0] o_bw_avail;
    logic        o_bw_load;
    int          num_errors;
    int          comparisons;
    int          loads;
    logic [7:0]  base;
    logic [31:0] full;
    logic [31:0] m;
    logic [31:0] v;

    iso_context_irq_regs iso_context_irq_regs_inst (
        .i_mclk(i_mclk), .i_nrst(i_nrst), .i_soft_rst(i_soft_rst),
        .i_global_reset_pin(bw_src[0]), .i_perst(bw_src[1]),
        .i_pci_bus_reset_pin(bw_src[2]), .i_serial_bus_reset(bw_src[3]),
        .i_tx_ctx_irq(i_tx_ctx_irq), .i_rx_ctx_irq(i_rx_ctx_irq),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_tx_summary_event(o_tx_summary_event),
        .o_rx_summary_event(o_rx_summary_event), .o_irq(o_irq),
        .o_bw_avail(o_bw_avail), .o_bw_load(o_bw_load));

    initial
    begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end

    task automatic final_report;
        $display("comparisons=%0d mismatches=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr    <= 1'b0;
    endtask

    // Read data is looked at only in the one cycle that it stands
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_mclk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd   <= 1'b0;
        #1;
        chk(o_rdata, exp);
    endtask

    // Summaries and the main request lag the latches by a cycle each
    task automatic settle;
        repeat (3) @(posedge i_mclk);
        #1;
    endtask

    initial
    begin
        #100us;
        num_errors++;
        final_report();
    end

    initial
    begin
        {i_nrst, i_soft_rst, bw_src, i_tx_ctx_irq, i_rx_ctx_irq} = '0;
        {i_addr, i_wdata, i_wr, i_rd} = '0;
        repeat (20) @(posedge i_mclk);
        i_nrst <= 1'b1;
        for (int a = 8'h90; a <= 8'hac; a += 4) rd(a[7:0], 32'h0);
        rd(8'hb0, 32'h0000_1333);
        chk({19'h0, o_bw_avail}, 32'h0000_1333);
        $display("reset value test done");
        for (int i = 0; i < 2; i++)
        begin
            base = i ? 8'ha0 : 8'h90;
            full = i ? 32'h0000_000f : 32'h0000_00ff;
            m = 32'h0000_00a5 & full;
            wr(base, 32'hffff_ffff);
            rd(base, full);
            rd(base + 8'h4, 32'h0);
            wr(base + 8'h8, 32'hffff_ffa5);
            rd(base + 8'h8, m);
            rd(base + 8'hc, m);
            rd(base + 8'h4, m);
            settle();
            chk({31'h0, i ? o_rx_summary_event : o_tx_summary_event}, 32'h1);
            wr(base + 8'h4, 32'h0);
            wr(base, 32'h0);
            rd(base, full);
            wr(base + 8'h4, 32'h0000_000f);
            rd(base, full & 32'hffff_fff0);
            wr(base + 8'hc, 32'hffff_ffff);
            rd(base + 8'h8, 32'h0);
            wr(base + 8'h4, full);
            settle();
            chk({31'h0, i ? o_rx_summary_event : o_tx_summary_event}, 32'h0);
            $display("register pair %0d test done", i);
        end
        @(posedge i_mclk);
        i_tx_ctx_irq <= 8'h81;
        i_rx_ctx_irq <= 4'h9;
        rd(8'h90, 32'h0000_0081);
        rd(8'ha0, 32'h0000_0009);
        wr(8'h94, 32'h0000_00ff);
        wr(8'ha4, 32'h0000_000f);
        rd(8'h90, 32'h0);
        rd(8'ha0, 32'h0);
        @(posedge i_mclk);
        i_tx_ctx_irq <= 8'h00;
        i_rx_ctx_irq <= 4'h0;
        $display("context edge test done");
        wr(8'hb8, 32'h0000_00c0);
        rd(8'hb8, 32'h0000_00c0);
        wr(8'h98, 32'h0000_0001);
        wr(8'h90, 32'h0000_0001);
        settle();
        chk({31'h0, o_irq}, 32'h1);
        rd(8'h94, 32'h0000_0001);
        wr(8'hb8, 32'h0000_0080);
        settle();
        chk({31'h0, o_irq}, 32'h0);
        wr(8'h94, 32'h0000_0001);
        wr(8'ha8, 32'h0000_0008);
        wr(8'ha0, 32'h0000_0008);
        wr(8'hb8, 32'h0000_0040);
        settle();
        chk({30'h0, o_rx_summary_event, o_irq}, 32'h2);
        wr(8'hb8, 32'h0000_00c0);
        settle();
        chk({31'h0, o_irq}, 32'h1);
        $display("main request test done");
        for (int j = 0; j < 4; j++)
        begin
            v = 32'hffff_f000 + j;
            wr(8'hb0, v);
            rd(8'hb0, v & 32'h0000_1fff);
            @(posedge i_mclk);
            bw_src <= 4'h1 << j;
            @(posedge i_mclk);
            bw_src <= 4'h0;
            loads = 0;
            repeat (3)
            begin
                #1;
                loads += o_bw_load;
                @(posedge i_mclk);
            end
            chk(loads, 32'h1);
            chk({19'h0, o_bw_avail}, v & 32'h0000_1fff);
            rd(8'hb0, v & 32'h0000_1fff);
        end
        $display("bandwidth load test done");
        wr(8'h84, 32'hffff_ffff);
        rd(8'h84, 32'h0);
        wr(8'h98, 32'h0000_00ff);
        wr(8'h90, 32'h0000_00ff);
        @(posedge i_mclk);
        i_soft_rst <= 1'b1;
        @(posedge i_mclk);
        i_soft_rst <= 1'b0;
        #1;
        chk({31'h0, o_bw_load}, 32'h1);
        rd(8'h90, 32'h0);
        rd(8'h98, 32'h0);
        rd(8'ha8, 32'h0);
        rd(8'hb0, 32'h0000_1333);
        chk({19'h0, o_bw_avail}, 32'h0000_1333);
        $display("soft reset test done");
        final_report();
    end
endmodule
